//--- verilog/irq_router_pkg.sv
/*
  Shared constants and types for the interrupt router with NMI status.
  Assumes an 8-bit I/O port bus with one-cycle read and write strobes.
*/
package irq_router_pkg;

  // I/O port addresses
  localparam logic [15:0] ADDR_ROUTE_SELECT = 16'h0C00;
  localparam logic [15:0] ADDR_ROUTE_TARGET = 16'h0C01;
  localparam logic [15:0] ADDR_ERROR_CTRL = 16'h0C14;
  localparam logic [15:0] ADDR_NMI_CLEAR_PORT = 16'h0061;
  localparam int NMI_CLEAR_BIT = 2;

  // Route source codes
  localparam logic [7:0] SRC_PCI_A = 8'h00;
  localparam logic [7:0] SRC_PCI_D = 8'h03;
  localparam logic [7:0] SRC_ACPI = 8'h04;
  localparam logic [7:0] SRC_SMBUS = 8'h05;
  localparam logic [7:0] SRC_PCI_E = 8'h09;
  localparam logic [7:0] SRC_PCI_H = 8'h0C;
  localparam int NUM_SRC_CODES = 13;
  localparam int ENTRY_W = 4;

  // Error register fields
  localparam int ERR_SERR_STATUS_BIT = 0;
  localparam int ERR_PERR_STATUS_BIT = 1;
  localparam int ERR_SERR_DIS_BIT = 2;
  localparam int ERR_PERR_DIS_BIT = 3;

  // Reset values
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [3:0] ENTRY_RESET = 4'h0;
  localparam logic NMI_DIS_RESET = 1'b1;

  // Interrupt controller geometry
  localparam int NUM_IRQ = 16;
  localparam int NUM_PCI_LINES = 8;
  localparam int NUM_APIC = 24;
  localparam int APIC_PCI_BASE = 16;
  localparam int APIC_SMBUS = 20;
  localparam int APIC_ACPI = 9;
  localparam int APIC_TIMER_LO = 22;
  localparam int APIC_TIMER_HI = 23;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } io_rsp_t;

endpackage : irq_router_pkg

//--- verilog/pci_irq_router_nmi.sv
/*
  Interrupt router: index/target routing of PCI, ACPI and SMBus sources onto
  legacy IRQ lines, fixed APIC input mapping in advanced mode, and SERR/PERR
  NMI status with active-low enables.
  Assumes all inputs synchronous to ref_clk and one-cycle I/O strobes.
*/
`timescale 1ns/1ps

// Operation
// - Select codes pick PCI, ACPI, SMBus sources
// - Target register accesses selected entry, resets zero
// - Entry bits 3:0 IRQ number, upper unused
// - Advanced mode maps IRQ 15:0 straight through
// - Advanced mode puts PCI H..A on 23..16
// - SMBus on input 20, ACPI on 9
// - Event timer selectable onto input 22 or 23
// - SERR assertion sets status bit 0 if enabled
// - PERR assertion sets status bit 1 if enabled
// - Status clears only via port 61h bit 2
// - Bit 2 disables SERR NMI, resets 1
// - Bit 3 disables PERR NMI, resets 1
module pci_irq_router_nmi (
  input wire logic ref_clk,
  input wire logic rst,
  input irq_router_pkg::io_req_t io_req,
  output irq_router_pkg::io_rsp_t io_rsp,
  input wire logic advanced_routing_mode,
  input wire logic timer_on_input_23,
  input wire logic [7:0] pci_int_n,
  input wire logic acpi_control_interrupt,
  input wire logic smbus_interrupt,
  input wire logic event_timer_interrupt,
  input wire logic [15:0] legacy_irq_in,
  input wire logic serr_n,
  input wire logic perr_n,
  output logic [15:0] pic_irq,
  output logic [23:0] apic_input_line,
  output logic nmi_request
);

  logic [7:0] select_q;
  logic [3:0] entry_q [irq_router_pkg::NUM_SRC_CODES];
  logic serr_dis_q;
  logic perr_dis_q;
  logic serr_status_q;
  logic perr_status_q;
  logic serr_n_q;
  logic perr_n_q;
  logic [12:0] src_active;
  logic [15:0] pic_d;
  logic [23:0] apic_d;
  logic wr_select;
  logic wr_target;
  logic wr_error;
  logic nmi_clear;
  logic serr_event;
  logic perr_event;
  logic select_valid;

  // Reserved codes 6h..8h and anything above Ch hold no entry
  assign select_valid = (select_q <= irq_router_pkg::SRC_SMBUS) ||
    ((select_q >= irq_router_pkg::SRC_PCI_E) &&
     (select_q <= irq_router_pkg::SRC_PCI_H));

  assign wr_select = io_req.wr && (io_req.addr == irq_router_pkg::ADDR_ROUTE_SELECT);
  assign wr_target = io_req.wr && (io_req.addr == irq_router_pkg::ADDR_ROUTE_TARGET);
  assign wr_error = io_req.wr && (io_req.addr == irq_router_pkg::ADDR_ERROR_CTRL);
  assign nmi_clear = io_req.wr && (io_req.addr == irq_router_pkg::ADDR_NMI_CLEAR_PORT) &&
    io_req.wdata[irq_router_pkg::NMI_CLEAR_BIT];

  // Sources indexed by their select code
  always_comb begin
    src_active = '0;
    for (int i = 0; i < 4; i++) begin
      src_active[i] = !pci_int_n[i];
      src_active[9 + i] = !pci_int_n[4 + i];
    end
    src_active[irq_router_pkg::SRC_ACPI[3:0]] = acpi_control_interrupt;
    src_active[irq_router_pkg::SRC_SMBUS[3:0]] = smbus_interrupt;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      select_q <= irq_router_pkg::SELECT_RESET;
    end else if (wr_select) begin
      select_q <= io_req.wdata;
    end
  end

  generate
    for (genvar g = 0; g < irq_router_pkg::NUM_SRC_CODES; g++) begin : g_entry
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          entry_q[g] <= irq_router_pkg::ENTRY_RESET;
        end else if (wr_target && select_valid && (select_q == 8'(g))) begin
          entry_q[g] <= io_req.wdata[3:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serr_dis_q <= irq_router_pkg::NMI_DIS_RESET;
      perr_dis_q <= irq_router_pkg::NMI_DIS_RESET;
    end else if (wr_error) begin
      serr_dis_q <= io_req.wdata[irq_router_pkg::ERR_SERR_DIS_BIT];
      perr_dis_q <= io_req.wdata[irq_router_pkg::ERR_PERR_DIS_BIT];
    end
  end

  // Read answer one cycle after the strobe; bits 7:4 of entries read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_rsp <= '0;
    end else begin
      io_rsp.valid <= 1'b0;
      io_rsp.data <= 8'h00;
      if (io_req.rd) begin
        case (io_req.addr)
          irq_router_pkg::ADDR_ROUTE_SELECT: begin
            io_rsp.valid <= 1'b1;
            io_rsp.data <= select_q;
          end
          irq_router_pkg::ADDR_ROUTE_TARGET: begin
            io_rsp.valid <= 1'b1;
            io_rsp.data <= select_valid ? {4'h0, entry_q[select_q[3:0]]} : 8'h00;
          end
          irq_router_pkg::ADDR_ERROR_CTRL: begin
            io_rsp.valid <= 1'b1;
            io_rsp.data <= {4'h0, perr_dis_q, serr_dis_q, perr_status_q, serr_status_q};
          end
          default: begin
            io_rsp.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // Edge detect so a held error line sets status once per assertion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serr_n_q <= 1'b1;
      perr_n_q <= 1'b1;
    end else begin
      serr_n_q <= serr_n;
      perr_n_q <= perr_n;
    end
  end

  assign serr_event = serr_n_q && !serr_n && !serr_dis_q;
  assign perr_event = perr_n_q && !perr_n && !perr_dis_q;

  // Set beats clear so a coincident error is not lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serr_status_q <= 1'b0;
      perr_status_q <= 1'b0;
    end else begin
      if (serr_event) begin
        serr_status_q <= 1'b1;
      end else if (nmi_clear) begin
        serr_status_q <= 1'b0;
      end
      if (perr_event) begin
        perr_status_q <= 1'b1;
      end else if (nmi_clear) begin
        perr_status_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nmi_request <= 1'b0;
    end else begin
      nmi_request <= serr_status_q || perr_status_q;
    end
  end

  // Entry value 0 means not routed; software keeps off reserved IRQs
  always_comb begin
    pic_d = legacy_irq_in;
    apic_d = '0;
    if (advanced_routing_mode) begin
      apic_d[15:0] = legacy_irq_in;
      for (int i = 0; i < irq_router_pkg::NUM_PCI_LINES; i++) begin
        apic_d[irq_router_pkg::APIC_PCI_BASE + i] = !pci_int_n[i];
      end
      apic_d[irq_router_pkg::APIC_SMBUS] = apic_d[irq_router_pkg::APIC_SMBUS] |
        smbus_interrupt;
      apic_d[irq_router_pkg::APIC_ACPI] = apic_d[irq_router_pkg::APIC_ACPI] |
        acpi_control_interrupt;
      if (timer_on_input_23) begin
        apic_d[irq_router_pkg::APIC_TIMER_HI] = apic_d[irq_router_pkg::APIC_TIMER_HI] |
          event_timer_interrupt;
      end else begin
        apic_d[irq_router_pkg::APIC_TIMER_LO] = apic_d[irq_router_pkg::APIC_TIMER_LO] |
          event_timer_interrupt;
      end
    end else begin
      for (int s = 0; s < irq_router_pkg::NUM_SRC_CODES; s++) begin
        if (src_active[s] && (entry_q[s] != 4'h0)) begin
          pic_d[entry_q[s]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pic_irq <= '0;
      apic_input_line <= '0;
    end else begin
      pic_irq <= pic_d;
      apic_input_line <= apic_d;
    end
  end

  // Checks
  sequence s_serr_edge_enabled;
    serr_n_q && !serr_n && !serr_dis_q;
  endsequence

  sequence s_status_set;
    serr_status_q || perr_status_q;
  endsequence

  a_serr_sets_status: assert property (@(posedge ref_clk) disable iff (rst)
    s_serr_edge_enabled |=> serr_status_q)
    else $error("SERR edge did not set status");

  a_perr_sets_status: assert property (@(posedge ref_clk) disable iff (rst)
    (perr_n_q && !perr_n && !perr_dis_q) |=> perr_status_q)
    else $error("PERR edge did not set status");

  a_status_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (serr_status_q && !nmi_clear) |=> serr_status_q)
    else $error("SERR status dropped without port clear");

  a_clear_drops: assert property (@(posedge ref_clk) disable iff (rst)
    (nmi_clear && !serr_event && !perr_event) |=> !serr_status_q && !perr_status_q)
    else $error("Port clear left status set");

  a_disabled_no_set: assert property (@(posedge ref_clk) disable iff (rst)
    (serr_dis_q && !serr_status_q) |=> !serr_status_q)
    else $error("Disabled SERR set status");

  a_perr_dis_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_error |=> (perr_dis_q == $past(io_req.wdata[3])))
    else $error("PERR disable bit not written");

  a_nmi_follows: assert property (@(posedge ref_clk) disable iff (rst)
    s_status_set |=> nmi_request)
    else $error("NMI request missing");

  a_apic_pci_a: assert property (@(posedge ref_clk) disable iff (rst)
    advanced_routing_mode |=> (apic_input_line[16] == !$past(pci_int_n[0])))
    else $error("PCI A not on APIC input 16");

  a_apic_acpi: assert property (@(posedge ref_clk) disable iff (rst)
    (advanced_routing_mode && acpi_control_interrupt) |=> apic_input_line[9])
    else $error("ACPI not on APIC input 9");

  // Input 9 also carries the ACPI interrupt, so it is masked here
  a_apic_passthru: assert property (@(posedge ref_clk) disable iff (rst)
    advanced_routing_mode |=>
      ((apic_input_line[15:0] & 16'hFDFF) == ($past(legacy_irq_in) & 16'hFDFF)))
    else $error("Legacy IRQ not passed to APIC");

  a_entry_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_target && select_q == 8'h01) |=> (entry_q[1] == $past(io_req.wdata[3:0])))
    else $error("Target write missed entry");

  a_route_legacy: assert property (@(posedge ref_clk) disable iff (rst)
    (!advanced_routing_mode && !pci_int_n[0] && entry_q[0] != 4'h0) |=>
      pic_irq[$past(entry_q[0])])
    else $error("PCI A not routed to IRQ");

  a_perr_holds: assert property (@(posedge ref_clk) disable iff (rst)
    (perr_status_q && !nmi_clear) |=> perr_status_q)
    else $error("PERR status dropped without port clear");

  a_perr_dis_no_set: assert property (@(posedge ref_clk) disable iff (rst)
    (perr_dis_q && !perr_status_q) |=> !perr_status_q)
    else $error("Disabled PERR set status");

  a_apic_smbus: assert property (@(posedge ref_clk) disable iff (rst)
    (advanced_routing_mode && smbus_interrupt) |=> apic_input_line[20])
    else $error("SMBus not on APIC input 20");

  a_timer_lo: assert property (@(posedge ref_clk) disable iff (rst)
    (advanced_routing_mode && event_timer_interrupt && !timer_on_input_23) |=>
      apic_input_line[22])
    else $error("Event timer not on APIC input 22");

  a_timer_hi: assert property (@(posedge ref_clk) disable iff (rst)
    (advanced_routing_mode && event_timer_interrupt && timer_on_input_23) |=>
      apic_input_line[23])
    else $error("Event timer not on APIC input 23");

  a_nmi_drops: assert property (@(posedge ref_clk) disable iff (rst)
    (!serr_status_q && !perr_status_q) |=> !nmi_request)
    else $error("NMI request left pending after clear");

endmodule : pci_irq_router_nmi

//--- verification/pci_agent_model.sv
/*
  Far-side model: PCI agents and error reporters on active-low lines.
  Assumes the bench raises requests at the falling clock edge.
*/
`timescale 1ns/1ps
module pci_agent_model (
  input wire logic [7:0] int_req,
  input wire logic serr_req,
  input wire logic perr_req,
  output logic [7:0] pci_int_n,
  output logic serr_n,
  output logic perr_n
);
  // Idle lines sit high as on the pulled-up bus
  assign pci_int_n = ~int_req;
  assign serr_n = ~serr_req;
  assign perr_n = ~perr_req;
endmodule : pci_agent_model

//--- verification/pci_irq_router_nmi_test.sv
/*
  Self-checking bench for the interrupt router: routing, APIC map, NMI status.
  Assumes one-cycle I/O strobes and read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module pci_irq_router_nmi_test;
  logic ref_clk, rst, adv, t23, acpi, smb, tmr, serr_req, perr_req, nmi_request;
  logic [7:0] int_req, pci_int_n;
  logic serr_n, perr_n;
  logic [15:0] legacy, pic_irq;
  logic [23:0] apic;
  irq_router_pkg::io_req_t io_req;
  irq_router_pkg::io_rsp_t io_rsp;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h04, 8'h05};
  // Targets avoid the reserved inputs 0, 2, 8 and 13
  logic [3:0] tgt [10] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hE, 4'hF};

  pci_agent_model agent (.int_req(int_req), .serr_req(serr_req), .perr_req(perr_req),
    .pci_int_n(pci_int_n), .serr_n(serr_n), .perr_n(perr_n));

  pci_irq_router_nmi DUT (.ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_rsp(io_rsp),
    .advanced_routing_mode(adv), .timer_on_input_23(t23), .pci_int_n(pci_int_n),
    .acpi_control_interrupt(acpi), .smbus_interrupt(smb), .event_timer_interrupt(tmr),
    .legacy_irq_in(legacy), .serr_n(serr_n), .perr_n(perr_n), .pic_irq(pic_irq),
    .apic_input_line(apic), .nmi_request(nmi_request));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Cut a hang short well beyond the expected 120 or so cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    io_req.wr = 1'b0;
  endtask : wr

  // Answer stands one cycle, looked at in that cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    io_req.rd = 1'b0;
    check(24'(io_rsp), {15'h0000, 1'b1, e});
  endtask : rd

  task automatic err_pulse(input logic s, input logic p);
    serr_req = s;
    perr_req = p;
    tick(1);
    serr_req = 1'b0;
    perr_req = 1'b0;
  endtask : err_pulse

  initial begin
    rst = 1'b1;
    io_req = '0;
    {adv, t23, acpi, smb, tmr, serr_req, perr_req} = 7'h00;
    int_req = 8'h00;
    legacy = 16'h0000;
    tick(2);
    rst = 1'b0;
    rd(irq_router_pkg::ADDR_ROUTE_SELECT, 8'h00);
    rd(irq_router_pkg::ADDR_ROUTE_TARGET, 8'h00);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h0C);
    check(apic, 24'h000000);
    for (int i = 0; i < 10; i++) begin
      wr(irq_router_pkg::ADDR_ROUTE_SELECT, codes[i]);
      wr(irq_router_pkg::ADDR_ROUTE_TARGET, {4'hF, tgt[i]});
      rd(irq_router_pkg::ADDR_ROUTE_TARGET, {4'h0, tgt[i]});
      if (i < 8) int_req = 8'h01 << i;
      acpi = (i == 8);
      smb = (i == 9);
      tick(1);
      check(pic_irq, 16'h0001 << tgt[i]);
      int_req = 8'h00;
      {acpi, smb} = 2'b00;
    end
    // Reserved code keeps no entry
    wr(irq_router_pkg::ADDR_ROUTE_SELECT, 8'h06);
    wr(irq_router_pkg::ADDR_ROUTE_TARGET, 8'h07);
    rd(irq_router_pkg::ADDR_ROUTE_TARGET, 8'h00);
    rd(irq_router_pkg::ADDR_ROUTE_SELECT, 8'h06);
    err_pulse(1'b1, 1'b1);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h0C);
    check(nmi_request, 1'b0);
    wr(irq_router_pkg::ADDR_ERROR_CTRL, 8'h08);
    err_pulse(1'b1, 1'b0);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h09);
    check(nmi_request, 1'b1);
    // Status and upper bits are read-only, so this write must not clear
    wr(irq_router_pkg::ADDR_ERROR_CTRL, 8'hFB);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h09);
    wr(irq_router_pkg::ADDR_NMI_CLEAR_PORT, 8'hFB);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h09);
    wr(irq_router_pkg::ADDR_NMI_CLEAR_PORT, 8'h04);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h08);
    check(nmi_request, 1'b0);
    wr(irq_router_pkg::ADDR_ERROR_CTRL, 8'h04);
    err_pulse(1'b1, 1'b1);
    rd(irq_router_pkg::ADDR_ERROR_CTRL, 8'h06);
    // Second reset clears the entries before the mode switch
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    adv = 1'b1;
    legacy = 16'h0021;
    int_req = 8'h81;
    {acpi, smb, tmr} = 3'b111;
    tick(2);
    check(apic, 24'hD10221);
    check(nmi_request, 1'b0);
    legacy = 16'h0000;
    int_req = 8'h00;
    {acpi, smb, t23} = 3'b001;
    tick(2);
    check(apic, 24'h800000);
    summarize();
  end
endmodule : pci_irq_router_nmi_test
